/* File: rtl/atsf_defines.vh */
`ifndef ATSF_DEFINES_VH
`define ATSF_DEFINES_VH

// Byte offsets of the word registers on the bus.
`define ATSF_OFF_STATUS 8'h00
`define ATSF_OFF_MASK 8'h04
`define ATSF_OFF_FLAGS 8'h08
`define ATSF_OFF_GTC 8'h0c
`define ATSF_OFF_CNT 8'h10
`define ATSF_OFF_CMP 8'h14
`define ATSF_OFF_CTL 8'h18
`define ATSF_OFF_NONE 8'hff
`define ATSF_HADDR_HI_ZERO 24'h000000
`define ATSF_RDATA_PAD 24'h000000

// Field positions.
`define ATSF_B_EXTERNAL_CLOCK_INPUT_ENABLE 4
`define ATSF_B_ASYNC 3
`define ATSF_B_UB_CNT 2
`define ATSF_B_UB_CMP 1
`define ATSF_B_UB_CTL 0
`define ATSF_B_CMP 1
`define ATSF_B_OVF 0
`define ATSF_B_TSM 7
`define ATSF_B_PSR 1
`define ATSF_B_WGM0 6
`define ATSF_B_WGM1 3
`define ATSF_CS_HI 2
`define ATSF_CS_LO 0
`define ATSF_HTRANS_ACT 1

// Reset values and masks.
`define ATSF_RST8 8'h00
`define ATSF_RST2 2'h0
`define ATSF_RST10 10'h000
`define ATSF_CTL_WMASK 8'h7f

// Waveform modes.
`define ATSF_MODE_NORMAL 2'h0
`define ATSF_MODE_PCPWM 2'h1
`define ATSF_MODE_CTC 2'h2
`define ATSF_MODE_FAST 2'h3

// Clock select codes and prescaler tap masks.
`define ATSF_CS_OFF 3'h0
`define ATSF_CS_DIV1 3'h1
`define ATSF_CS_DIV8 3'h2
`define ATSF_CS_DIV32 3'h3
`define ATSF_CS_DIV64 3'h4
`define ATSF_CS_DIV128 3'h5
`define ATSF_CS_DIV256 3'h6
`define ATSF_PM_1 10'h000
`define ATSF_PM_8 10'h007
`define ATSF_PM_32 10'h01f
`define ATSF_PM_64 10'h03f
`define ATSF_PM_128 10'h07f
`define ATSF_PM_256 10'h0ff
`define ATSF_PM_1024 10'h3ff
`define ATSF_PRESC_ONE 10'h001

// Counter limits.
`define ATSF_CNT_MAX 8'hff
`define ATSF_CNT_BOT 8'h00
`define ATSF_CNT_ONE 8'h01

`endif

/* File: rtl/atsf_pin_sync.v */
`timescale 1ns/1ps
// Three-stage pin synchroniser; the level moves only once stages two and
// three agree, so a single-cycle glitch past stage two is ignored.
module atsf_pin_sync (
    input wire clk,      // System clock.
    input wire sys_rst,  // Synchronous reset, active high.
    input wire ce,       // Clock enable.
    input wire pin_in,   // Asynchronous pin.
    output reg level_q   // Filtered, synchronised level.
);
    reg s1_q;
    reg s2_q;
    reg s3_q;

    always @(posedge clk) begin
        if (sys_rst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            level_q <= 1'b0;
        end else if (ce) begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                level_q <= s3_q;
            end
        end
    end
endmodule

/* File: rtl/atsf_timer_sync.v */
// Chosen here: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
`include "atsf_defines.vh"

module atsf_timer_sync (
    input wire clk,                 // System clock, 100 MHz.
    input wire sys_rst,             // Synchronous reset, active high.
    input wire ce,                  // Clock enable; low freezes all state.
    input wire hsel,                // AHB-Lite slave select.
    input wire [31:0] haddr,        // AHB-Lite address.
    input wire [1:0] htrans,        // AHB-Lite transfer type.
    input wire hwrite,              // AHB-Lite write strobe.
    input wire [2:0] hsize,         // AHB-Lite size, words only.
    input wire [31:0] hwdata,       // AHB-Lite write data.
    input wire hready,              // AHB-Lite bus ready.
    output reg [31:0] hrdata,       // AHB-Lite read data.
    output wire hreadyout,          // AHB-Lite slave ready.
    output wire hresp,              // AHB-Lite response, always OKAY.
    input wire osc_pin_in,          // Oscillator input pin level.
    output wire crystal_osc_run,    // Crystal oscillator enable.
    output wire ext_clk_buf_en,     // External clock input buffer enable.
    input wire global_irq_enable,   // Global interrupt enable from the CPU.
    input wire compare_vector_ack,  // Compare vector executed, pulse.
    input wire overflow_vector_ack, // Overflow vector executed, pulse.
    output wire irq,                // Combined interrupt request, level.
    output wire irq_compare,        // Compare-match interrupt request.
    output wire irq_overflow        // Overflow interrupt request.
);
    reg external_clock_input_enable_q;
    reg async_clock_select_q;
    reg counter_update_pending_q;
    reg compare_update_pending_q;
    reg control_update_pending_q;
    reg [7:0] counter_value_q;
    reg [7:0] counter_tmp_q;
    reg [7:0] compare_value_a_q;
    reg [7:0] compare_tmp_q;
    reg [7:0] timer_control_a_q;
    reg [7:0] control_tmp_q;
    reg [1:0] timer_irq_mask_q;
    reg [1:0] timer_irq_flags_q;
    reg sync_hold_mode_q;
    reg prescaler_reset_request_q;
    reg [9:0] presc_q;
    reg count_up_q, match_block_q, pin_prev_q;
    reg dph_q, dwr_q, rd_wait_q;
    reg [7:0] dadr_q;

    wire pin_level, pin_rise, async_edge, src_tick;
    wire bus_acc, wr_en;
    wire [7:0] wd;
    wire wr_status, wr_mask, wr_flags, wr_gtc;
    wire wr_cnt, wr_cmp, wr_ctl;
    wire psr_wr, tsm_next, presc_clr;
    wire [2:0] clock_source_select;
    wire [1:0] wgm;
    wire timer_tick;
    wire cnt_load, cmp_load, ctl_load;
    wire cmp_hit, ovf_hit;
    wire [1:0] flag_set, flag_clr, irq_pend;

    reg [9:0] tap_mask;
    reg [7:0] rdata;
    reg prescaler_reset_d;

    atsf_pin_sync u_pin_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .ce(ce),
        .pin_in(osc_pin_in),
        .level_q(pin_level)
    );

    // Bus side: reads take one wait state so that read data is registered
    // after any write from the previous data phase has landed.
    assign hreadyout = ce & ~rd_wait_q;
    assign hresp = 1'b0;
    assign bus_acc = ce & hsel & hready & htrans[`ATSF_HTRANS_ACT];
    assign wr_en = ce & dph_q & dwr_q;
    assign wd = hwdata[7:0];
    assign wr_status = wr_en & (dadr_q == `ATSF_OFF_STATUS);
    assign wr_mask = wr_en & (dadr_q == `ATSF_OFF_MASK);
    assign wr_flags = wr_en & (dadr_q == `ATSF_OFF_FLAGS);
    assign wr_gtc = wr_en & (dadr_q == `ATSF_OFF_GTC);
    assign wr_cnt = wr_en & (dadr_q == `ATSF_OFF_CNT);
    assign wr_cmp = wr_en & (dadr_q == `ATSF_OFF_CMP);
    assign wr_ctl = wr_en & (dadr_q == `ATSF_OFF_CTL);

    always @(posedge clk) begin
        if (sys_rst) begin
            dph_q <= 1'b0;
            dwr_q <= 1'b0;
            rd_wait_q <= 1'b0;
            dadr_q <= `ATSF_OFF_NONE;
            hrdata <= {`ATSF_RDATA_PAD, `ATSF_RST8};
        end else if (ce) begin
            if (rd_wait_q) begin
                hrdata <= {`ATSF_RDATA_PAD, rdata};
                rd_wait_q <= 1'b0;
            end
            if (bus_acc) begin
                dph_q <= 1'b1;
                dwr_q <= hwrite;
                rd_wait_q <= ~hwrite;
                if (haddr[31:8] == `ATSF_HADDR_HI_ZERO) begin
                    dadr_q <= haddr[7:0];
                end else begin
                    dadr_q <= `ATSF_OFF_NONE;
                end
            end else if (hreadyout) begin
                dph_q <= 1'b0;
                dwr_q <= 1'b0;
            end
        end
    end

    always @* begin
        case (dadr_q)
            `ATSF_OFF_STATUS: begin
                rdata = {3'h0, external_clock_input_enable_q,
                    async_clock_select_q, counter_update_pending_q,
                    compare_update_pending_q, control_update_pending_q};
            end
            `ATSF_OFF_MASK: begin
                rdata = {6'h00, timer_irq_mask_q};
            end
            `ATSF_OFF_FLAGS: begin
                rdata = {6'h00, timer_irq_flags_q};
            end
            `ATSF_OFF_GTC: begin
                rdata = {sync_hold_mode_q, 5'h00,
                    prescaler_reset_request_q, 1'b0};
            end
            `ATSF_OFF_CNT: begin
                rdata = counter_value_q;
            end
            `ATSF_OFF_CMP: begin
                rdata = compare_tmp_q;
            end
            `ATSF_OFF_CTL: begin
                rdata = control_tmp_q;
            end
            default: begin
                rdata = `ATSF_RST8;
            end
        endcase
    end

    // Clock source: the pin is only a clock while asynchronous mode is on.
    assign pin_rise = pin_level & ~pin_prev_q;
    assign async_edge = async_clock_select_q & pin_rise;
    assign src_tick = async_clock_select_q ? pin_rise : 1'b1;
    assign ext_clk_buf_en = async_clock_select_q &
        external_clock_input_enable_q;
    assign crystal_osc_run = async_clock_select_q &
        ~external_clock_input_enable_q;

    always @(posedge clk) begin
        if (sys_rst) begin
            pin_prev_q <= 1'b0;
            external_clock_input_enable_q <= 1'b0;
            async_clock_select_q <= 1'b0;
            timer_irq_mask_q <= `ATSF_RST2;
            sync_hold_mode_q <= 1'b0;
        end else if (ce) begin
            pin_prev_q <= pin_level;
            if (wr_status) begin
                external_clock_input_enable_q <= wd[`ATSF_B_EXTERNAL_CLOCK_INPUT_ENABLE];
                async_clock_select_q <= wd[`ATSF_B_ASYNC];
            end
            if (wr_mask) begin
                timer_irq_mask_q <= {wd[`ATSF_B_CMP], wd[`ATSF_B_OVF]};
            end
            if (wr_gtc) begin
                sync_hold_mode_q <= wd[`ATSF_B_TSM];
            end
        end
    end

    // Prescaler and its reset request.
    assign psr_wr = wr_gtc & wd[`ATSF_B_PSR];
    assign tsm_next = wr_gtc ? wd[`ATSF_B_TSM] : sync_hold_mode_q;
    assign presc_clr = psr_wr | prescaler_reset_request_q;

    always @* begin
        prescaler_reset_d = 1'b0;
        if (presc_clr) begin
            if (tsm_next) begin
                prescaler_reset_d = 1'b1;
            end else if (async_clock_select_q) begin
                prescaler_reset_d = ~async_edge;
            end else begin
                prescaler_reset_d = 1'b0;
            end
        end
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            presc_q <= `ATSF_RST10;
            prescaler_reset_request_q <= 1'b0;
        end else if (ce) begin
            prescaler_reset_request_q <= prescaler_reset_d;
            if (presc_clr) begin
                presc_q <= `ATSF_RST10;
            end else if (src_tick) begin
                presc_q <= presc_q + `ATSF_PRESC_ONE;
            end
        end
    end

    assign clock_source_select =
        timer_control_a_q[`ATSF_CS_HI:`ATSF_CS_LO];
    assign wgm = {timer_control_a_q[`ATSF_B_WGM1],
        timer_control_a_q[`ATSF_B_WGM0]};

    always @* begin
        case (clock_source_select)
            `ATSF_CS_DIV1: tap_mask = `ATSF_PM_1;
            `ATSF_CS_DIV8: tap_mask = `ATSF_PM_8;
            `ATSF_CS_DIV32: tap_mask = `ATSF_PM_32;
            `ATSF_CS_DIV64: tap_mask = `ATSF_PM_64;
            `ATSF_CS_DIV128: tap_mask = `ATSF_PM_128;
            `ATSF_CS_DIV256: tap_mask = `ATSF_PM_256;
            default: tap_mask = `ATSF_PM_1024;
        endcase
    end

    assign timer_tick = src_tick & ~presc_clr &
        (clock_source_select != `ATSF_CS_OFF) &
        ((presc_q & tap_mask) == tap_mask);

    // Staged loads: synchronous mode loads on the write itself, asynchronous
    // mode waits for the next pin clock edge.
    assign cnt_load = async_clock_select_q ?
        (async_edge & counter_update_pending_q) : wr_cnt;
    assign cmp_load = async_clock_select_q ?
        (async_edge & compare_update_pending_q) : wr_cmp;
    assign ctl_load = async_clock_select_q ?
        (async_edge & control_update_pending_q) : wr_ctl;

    assign cmp_hit = timer_tick & ~match_block_q &
        (counter_value_q == compare_value_a_q);
    assign ovf_hit = timer_tick & ((wgm == `ATSF_MODE_PCPWM) ?
        (~count_up_q & (counter_value_q == `ATSF_CNT_BOT)) :
        (counter_value_q == `ATSF_CNT_MAX));

    always @(posedge clk) begin
        if (sys_rst) begin
            counter_tmp_q <= `ATSF_RST8;
            compare_tmp_q <= `ATSF_RST8;
            control_tmp_q <= `ATSF_RST8;
            compare_value_a_q <= `ATSF_RST8;
            timer_control_a_q <= `ATSF_RST8;
            counter_update_pending_q <= 1'b0;
            compare_update_pending_q <= 1'b0;
            control_update_pending_q <= 1'b0;
        end else if (ce) begin
            if (wr_cnt) begin
                counter_tmp_q <= wd;
            end
            if (wr_cmp) begin
                compare_tmp_q <= wd;
            end
            if (wr_ctl) begin
                control_tmp_q <= wd & `ATSF_CTL_WMASK;
            end
            if (cmp_load) begin
                compare_value_a_q <= async_clock_select_q ?
                    compare_tmp_q : wd;
            end
            if (ctl_load) begin
                timer_control_a_q <= async_clock_select_q ?
                    control_tmp_q : (wd & `ATSF_CTL_WMASK);
            end
            // A new write in the cycle of a load keeps the flag set.
            counter_update_pending_q <= async_clock_select_q &
                ((counter_update_pending_q & ~async_edge) | wr_cnt);
            compare_update_pending_q <= async_clock_select_q &
                ((compare_update_pending_q & ~async_edge) | wr_cmp);
            control_update_pending_q <= async_clock_select_q &
                ((control_update_pending_q & ~async_edge) | wr_ctl);
        end
    end

    // Counter; a load suppresses the compare match on the next timer tick.
    always @(posedge clk) begin
        if (sys_rst) begin
            counter_value_q <= `ATSF_RST8;
            count_up_q <= 1'b1;
            match_block_q <= 1'b0;
        end else if (ce) begin
            if (cnt_load) begin
                counter_value_q <= async_clock_select_q ?
                    counter_tmp_q : wd;
                match_block_q <= 1'b1;
            end else if (timer_tick) begin
                match_block_q <= 1'b0;
                case (wgm)
                    `ATSF_MODE_PCPWM: begin
                        if (count_up_q) begin
                            if (counter_value_q == `ATSF_CNT_MAX) begin
                                count_up_q <= 1'b0;
                                counter_value_q <= counter_value_q -
                                    `ATSF_CNT_ONE;
                            end else begin
                                counter_value_q <= counter_value_q +
                                    `ATSF_CNT_ONE;
                            end
                        end else if (counter_value_q == `ATSF_CNT_BOT) begin
                            count_up_q <= 1'b1;
                            counter_value_q <= `ATSF_CNT_ONE;
                        end else begin
                            counter_value_q <= counter_value_q -
                                `ATSF_CNT_ONE;
                        end
                    end
                    `ATSF_MODE_CTC: begin
                        count_up_q <= 1'b1;
                        if (counter_value_q == compare_value_a_q) begin
                            counter_value_q <= `ATSF_CNT_BOT;
                        end else begin
                            counter_value_q <= counter_value_q +
                                `ATSF_CNT_ONE;
                        end
                    end
                    default: begin
                        count_up_q <= 1'b1;
                        counter_value_q <= counter_value_q + `ATSF_CNT_ONE;
                    end
                endcase
            end
        end
    end

    // Interrupt flags: a hardware set wins over a clear in the same cycle.
    assign flag_set = {cmp_hit, ovf_hit};
    assign flag_clr = ({2{wr_flags}} & {wd[`ATSF_B_CMP], wd[`ATSF_B_OVF]}) |
        {compare_vector_ack, overflow_vector_ack};

    always @(posedge clk) begin
        if (sys_rst) begin
            timer_irq_flags_q <= `ATSF_RST2;
        end else if (ce) begin
            timer_irq_flags_q <= (timer_irq_flags_q & ~flag_clr) | flag_set;
        end
    end

    assign irq_pend = timer_irq_flags_q & timer_irq_mask_q &
        {2{global_irq_enable}};
    assign irq_compare = irq_pend[`ATSF_B_CMP];
    assign irq_overflow = irq_pend[`ATSF_B_OVF];
    assign irq = |irq_pend;
endmodule

/* File: dv/atsf_timer_sync_props.sv */
`timescale 1ns/1ps
module atsf_timer_sync_props (
    input wire clk,               // System clock.
    input wire sys_rst,           // Synchronous reset, active high.
    input wire ce,                // Clock enable.
    input wire hsel,              // Slave select.
    input wire [1:0] htrans,      // Transfer type.
    input wire hwrite,            // Write strobe.
    input wire hready,            // Bus ready.
    input wire [31:0] hrdata,     // Read data.
    input wire hreadyout,         // Slave ready.
    input wire hresp,             // Response.
    input wire crystal_osc_run,   // Crystal enable.
    input wire ext_clk_buf_en,    // External buffer enable.
    input wire global_irq_enable, // Global interrupt enable.
    input wire irq,               // Combined request.
    input wire irq_compare,       // Compare request.
    input wire irq_overflow       // Overflow request.
);
    wire take = hsel & hready & htrans[1] & ce;
    wire rd_take = take & ~hwrite;
    wire wr_take = take & hwrite;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    AST_OSC_EXCL: assert property (!(crystal_osc_run && ext_clk_buf_en))
        else $error("crystal and external buffer both enabled");
    // The source only moves when a write ended one cycle earlier.
    AST_OSC_CAUSE: assert property (
        !$stable({crystal_osc_run, ext_clk_buf_en}) |-> $past(wr_take, 2))
        else $error("clock source changed without a write");
    AST_IRQ_OR: assert property (irq == (irq_compare | irq_overflow))
        else $error("combined request differs from sources");
    AST_CMP_GIE: assert property (irq_compare |-> global_irq_enable)
        else $error("compare request without global enable");
    AST_OVF_GIE: assert property (irq_overflow |-> global_irq_enable)
        else $error("overflow request without global enable");
    AST_HRESP: assert property (hresp == 1'b0)
        else $error("response not okay");
    AST_RD_WAIT: assert property (rd_take |=> !hreadyout ##1 hreadyout)
        else $error("read did not take exactly one wait");
    AST_WR_ZERO: assert property (wr_take |=> hreadyout)
        else $error("write data phase stalled");
    AST_RST_VAL: assert property (@(posedge clk) disable iff (!ce)
        sys_rst |=> hrdata == 32'h0 && !irq && !crystal_osc_run)
        else $error("outputs not cleared by reset");

    cover property (rd_take);
    cover property (irq_compare);
    cover property (irq_overflow);
    cover property (ext_clk_buf_en);
endmodule

bind atsf_timer_sync atsf_timer_sync_props u_props (
    .clk, .sys_rst, .ce, .hsel, .htrans, .hwrite, .hready, .hrdata,
    .hreadyout, .hresp, .crystal_osc_run, .ext_clk_buf_en,
    .global_irq_enable, .irq, .irq_compare, .irq_overflow
);

/* File: dv/atsf_osc_model.sv */
`timescale 1ns/1ps
module atsf_osc_model #(
    parameter int HALF_NS = 103  // Half period, unrelated to clk.
) (
    input wire logic run,  // Design enables crystal or buffer.
    input wire logic go,   // Bench lets the source oscillate.
    output logic pin       // Oscillator pin level.
);
    initial pin = 1'b0;
    // The pin idles low whenever no source is enabled.
    always begin
        #(HALF_NS);
        if (run && go) begin
            pin = ~pin;
        end else begin
            pin = 1'b0;
        end
    end
endmodule

/* File: dv/atsf_timer_sync_bench.sv */
`timescale 1ns/1ps
`include "atsf_defines.vh"
module atsf_timer_sync_bench;
    logic clk;
    logic sys_rst;
    logic ce;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic gie;
    logic cmp_ack;
    logic ovf_ack;
    logic go;
    wire [31:0] hrdata;
    wire hready;
    wire hresp;
    wire osc_pin;
    wire xtal;
    wire ext_en;
    wire irq;
    wire irq_cmp;
    wire irq_ovf;
    int err_count;
    int checked;
    int i;

    atsf_timer_sync uut (
        .clk(clk), .sys_rst(sys_rst), .ce(ce), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hready), .hresp(hresp), .osc_pin_in(osc_pin),
        .crystal_osc_run(xtal), .ext_clk_buf_en(ext_en),
        .global_irq_enable(gie), .compare_vector_ack(cmp_ack),
        .overflow_vector_ack(ovf_ack), .irq(irq), .irq_compare(irq_cmp),
        .irq_overflow(irq_ovf)
    );

    atsf_osc_model osc (.run(xtal | ext_en), .go(go), .pin(osc_pin));

    always #5 clk = ~clk;

    task automatic conclude;
        if (err_count == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input string nm, input [7:0] e, input [7:0] g);
        checked++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            err_count++;
        end
    endtask

    // Waits for hready high at a rising edge; returns just after it.
    task automatic wait_rdy;
        int n;
        begin
            n = 0;
            @(negedge clk);
            while (hready !== 1'b1 && n < 64) begin
                @(negedge clk);
                n++;
            end
            if (hready !== 1'b1) begin
                chk("hready", 8'h01, {7'h0, hready});
                conclude;
            end else begin
                @(posedge clk);
            end
        end
    endtask

    task automatic wr(input [7:0] a, input [7:0] d);
        hsel <= 1'b1;
        hwrite <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        wait_rdy;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        wait_rdy;
    endtask

    task automatic rd(input [7:0] a, output [7:0] d);
        hsel <= 1'b1;
        hwrite <= 1'b0;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        wait_rdy;
        hsel <= 1'b0;
        htrans <= 2'h0;
        wait_rdy;
        d = hrdata[7:0];
    endtask

    task automatic rd_chk(input [7:0] a, input [7:0] e);
        logic [7:0] d;
        begin
            rd(a, d);
            chk("register", e, d);
        end
    endtask

    task automatic poll(input [7:0] a, input [7:0] m, input [7:0] e);
        logic [7:0] d;
        int n;
        begin
            n = 0;
            rd(a, d);
            while ((d & m) !== e && n < 100) begin
                rd(a, d);
                n++;
            end
            chk("poll", e, d & m);
            if ((d & m) !== e)
                conclude;
        end
    endtask

    task automatic pins(input [7:0] ei, input [7:0] eo);
        @(negedge clk);
        chk("irq", ei, {5'h0, irq, irq_cmp, irq_ovf});
        chk("osc", eo, {6'h0, xtal, ext_en});
        @(posedge clk);
    endtask

    initial begin
        clk = 1'b0;
        sys_rst = 1'b1;
        ce = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        gie = 1'b0;
        cmp_ack = 1'b0;
        ovf_ack = 1'b0;
        go = 1'b0;
        err_count = 0;
        checked = 0;
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        // Reset values of all registers and the unmapped word at 0x1c.
        for (i = 0; i < 8; i++)
            rd_chk({i[5:0], 2'b00}, 8'h00);
        wr(8'h1c, 8'hff);
        rd_chk(8'h1c, 8'h00);
        // Synchronous run from the system clock.
        wr(`ATSF_OFF_CNT, 8'h55);
        rd_chk(`ATSF_OFF_CNT, 8'h55);
        wr(`ATSF_OFF_CMP, 8'h03);
        wr(`ATSF_OFF_CTL, 8'h81);
        rd_chk(`ATSF_OFF_CTL, 8'h01);
        repeat (300) @(posedge clk);
        wr(`ATSF_OFF_CTL, 8'h00);
        rd_chk(`ATSF_OFF_FLAGS, 8'h03);
        pins(8'h00, 8'h00);
        gie <= 1'b1;
        pins(8'h00, 8'h00);
        wr(`ATSF_OFF_MASK, 8'h03);
        rd_chk(`ATSF_OFF_MASK, 8'h03);
        pins(8'h07, 8'h00);
        wr(`ATSF_OFF_FLAGS, 8'h01);
        rd_chk(`ATSF_OFF_FLAGS, 8'h02);
        pins(8'h06, 8'h00);
        cmp_ack <= 1'b1;
        @(posedge clk);
        cmp_ack <= 1'b0;
        @(posedge clk);
        rd_chk(`ATSF_OFF_FLAGS, 8'h00);
        pins(8'h00, 8'h00);
        // Phase-correct mode flags overflow only on turning at bottom.
        wr(`ATSF_OFF_CNT, 8'h02);
        wr(`ATSF_OFF_CTL, 8'h41);
        repeat (300) @(posedge clk);
        rd_chk(`ATSF_OFF_FLAGS, 8'h02);
        repeat (300) @(posedge clk);
        wr(`ATSF_OFF_CTL, 8'h00);
        rd_chk(`ATSF_OFF_FLAGS, 8'h03);
        ovf_ack <= 1'b1;
        @(posedge clk);
        ovf_ack <= 1'b0;
        @(posedge clk);
        rd_chk(`ATSF_OFF_FLAGS, 8'h02);
        wr(`ATSF_OFF_FLAGS, 8'h02);
        rd_chk(`ATSF_OFF_FLAGS, 8'h00);
        // Prescaler reset in synchronous mode, then under sync hold.
        wr(`ATSF_OFF_GTC, 8'h02);
        rd_chk(`ATSF_OFF_GTC, 8'h00);
        wr(`ATSF_OFF_GTC, 8'h82);
        rd_chk(`ATSF_OFF_GTC, 8'h82);
        wr(`ATSF_OFF_GTC, 8'h00);
        rd_chk(`ATSF_OFF_GTC, 8'h00);
        // Clear-on-match mode on the divide-by-8 tap never overflows.
        wr(`ATSF_OFF_CNT, 8'h00);
        wr(`ATSF_OFF_CMP, 8'h02);
        wr(`ATSF_OFF_CTL, 8'h0a);
        repeat (100) @(posedge clk);
        wr(`ATSF_OFF_CTL, 8'h00);
        rd_chk(`ATSF_OFF_FLAGS, 8'h02);
        wr(`ATSF_OFF_FLAGS, 8'h02);
        rd_chk(`ATSF_OFF_FLAGS, 8'h00);
        // Clock source selection.
        wr(`ATSF_OFF_STATUS, 8'h08);
        pins(8'h00, 8'h02);
        wr(`ATSF_OFF_STATUS, 8'h00);
        wr(`ATSF_OFF_STATUS, 8'h10);
        pins(8'h00, 8'h00);
        wr(`ATSF_OFF_STATUS, 8'h18);
        pins(8'h00, 8'h01);
        // Staged writes while the source is held still.
        wr(`ATSF_OFF_CTL, 8'h40);
        wr(`ATSF_OFF_CNT, 8'h20);
        wr(`ATSF_OFF_CMP, 8'h40);
        rd_chk(`ATSF_OFF_STATUS, 8'h1f);
        rd_chk(`ATSF_OFF_CMP, 8'h40);
        rd_chk(`ATSF_OFF_CTL, 8'h40);
        go <= 1'b1;
        poll(`ATSF_OFF_STATUS, 8'h07, 8'h00);
        rd_chk(`ATSF_OFF_STATUS, 8'h18);
        rd_chk(`ATSF_OFF_CNT, 8'h20);
        // Prescaler reset held until the next source edge.
        go <= 1'b0;
        repeat (40) @(posedge clk);
        wr(`ATSF_OFF_GTC, 8'h02);
        rd_chk(`ATSF_OFF_GTC, 8'h02);
        go <= 1'b1;
        poll(`ATSF_OFF_GTC, 8'h02, 8'h00);
        conclude;
    end
endmodule
